// ===== shared/icsp_pkg.sv
package icsp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Target address and subaddress classes
   localparam logic [6:0]  ICSP_DEV_ADDR  = 7'h1B;       // 0011 011
   localparam logic [7:0]  ICSP_CTRL_LAST = 8'h1F;       // Status and general control
   localparam logic [7:0]  ICSP_PROC_LAST = 8'h28;       // Single processing words
   localparam logic [7:0]  ICSP_BIQ_LAST  = 8'h3F;       // Filter coefficient sets
   localparam logic [4:0]  ICSP_LEN_CTRL  = 5'h01;       // Bytes per control register
   localparam logic [4:0]  ICSP_LEN_WORD  = 5'h04;       // Bytes per processing word
   localparam logic [4:0]  ICSP_LEN_BIQ   = 5'h14;       // Five 32-bit words
   localparam int          ICSP_BIQ_WORDS = 5;
   localparam int          ICSP_BUF_BITS  = 160;
   localparam logic [31:0] ICSP_CTRL_MASK = 32'h000000FF;
   localparam logic [31:0] ICSP_COEF_MASK = 32'h03FFFFFF; // 26-bit coefficients
   localparam logic [31:0] ICSP_WORD_MASK = 32'hFFFFFFFF;

   ////////////////////////////////////////////////////////////////////////////////
   // Bit framing
   localparam logic [3:0]  ICSP_BIT_LAST  = 4'h7;        // Eighth data bit
   localparam logic [3:0]  ICSP_BIT_ACK   = 4'h8;        // Acknowledge slot

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int ICSP_CORE_HZ     = 100_000_000;
   localparam int ICSP_SCL_STD_HZ  = 100_000;
   localparam int ICSP_SCL_FAST_HZ = 400_000;
   // Quarter bit period, rounded up so the fast-mode limit is never exceeded
   localparam int ICSP_QTR_CYC =
      (ICSP_CORE_HZ + 4 * ICSP_SCL_FAST_HZ - 1) / (4 * ICSP_SCL_FAST_HZ);

   ////////////////////////////////////////////////////////////////////////////////
   // State encodings, Gray along the usual path
   typedef enum logic [2:0] {
      ICSP_D_ADDR   = 3'h0,
      ICSP_D_SUB    = 3'h1,
      ICSP_D_WDATA  = 3'h3,
      ICSP_D_RDATA  = 3'h2,
      ICSP_D_IGNORE = 3'h6
   } icsp_dev_st_t;

   typedef enum logic [1:0] {
      ICSP_H_IDLE  = 2'h0,
      ICSP_H_START = 2'h1,
      ICSP_H_BITS  = 2'h3,
      ICSP_H_STOP  = 2'h2
   } icsp_host_st_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Register class helpers
   function automatic logic [4:0] icsp_reg_len(input logic [7:0] sub);
      if (sub <= ICSP_CTRL_LAST)
         return ICSP_LEN_CTRL;
      else if (sub <= ICSP_PROC_LAST)
         return ICSP_LEN_WORD;
      else if (sub <= ICSP_BIQ_LAST)
         return ICSP_LEN_BIQ;
      else
         return ICSP_LEN_WORD;
   endfunction

   function automatic logic [31:0] icsp_reg_mask(input logic [7:0] sub);
      if (sub <= ICSP_CTRL_LAST)
         return ICSP_CTRL_MASK;
      else if (sub > ICSP_PROC_LAST && sub <= ICSP_BIQ_LAST)
         return ICSP_COEF_MASK;
      else
         return ICSP_WORD_MASK;
   endfunction

endpackage

// ===== shared/icsp_if.sv
`timescale 1ns/1ps
interface icsp_if;
   // Clock line, only ever driven by the master
   logic scl;
   // Data line drivers and resolved level
   logic sda_host_o;
   logic sda_host_en_n;
   logic sda_dev_o;
   logic sda_dev_en_n;
   logic sda;

   // Wired-AND with pull-up: a released driver reads as high
   assign sda = (sda_host_en_n | sda_host_o) & (sda_dev_en_n | sda_dev_o);

   modport host (output scl, output sda_host_o, output sda_host_en_n, input sda);
   modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_en_n);
endinterface

// ===== verilog/icsp_dev.sv
`timescale 1ns/1ps
module icsp_dev
   import icsp_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = ICSP_DEV_ADDR
)
(
   // Core clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   // Two-wire bus
   icsp_if.dev               bus,
   // Committed register writes, core domain
   output logic              wr_valid_o,
   output logic [7:0]        wr_sub_o,
   output logic [4:0]        wr_len_o,
   output logic [159:0]      wr_data_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                     start_tgl_q;
   logic                     start_seen_q;
   logic                     start_pend;
   icsp_dev_st_t             st_q;
   logic [3:0]               cnt_q;
   logic [6:0]               shift_q;
   logic                     ack_q;
   logic [7:0]               ptr_q;
   logic [4:0]               bidx_q;
   logic [ICSP_BUF_BITS-1:0] wbuf_q;
   logic [7:0]               rx_byte;
   logic [ICSP_BUF_BITS-1:0] wfull;
   logic [4:0]               len;
   logic [31:0]              mask;
   logic                     byte_done;
   logic                     addr_hit;
   logic                     commit;
   logic                     mack;
   logic [31:0]              rd_word;
   logic [7:0]               rd_byte;
   logic                     sda_low_q;
   logic [31:0]              img [256][ICSP_BIQ_WORDS];
   logic                     com_tgl_q;
   logic [7:0]               com_sub_q;
   logic [4:0]               com_len_q;
   logic [ICSP_BUF_BITS-1:0] com_data_q;
   logic [2:0]               sync_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Start detection: data falls while clock high
   // Clocked by the data line; the master always leaves a setup time before the
   // next clock rise, so the link domain can read the toggle directly.
   always_ff @(negedge bus.sda or posedge rst_i)
   begin
      if (rst_i)
         start_tgl_q <= 1'b0;
      else if (bus.scl)
         start_tgl_q <= ~start_tgl_q;
   end

   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
         start_seen_q <= 1'b0;
      else
         start_seen_q <= start_tgl_q;
   end

   assign start_pend = start_tgl_q ^ start_seen_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte decode terms, link domain
   always_comb
   begin
      rx_byte   = {shift_q, bus.sda};
      wfull     = {wbuf_q[ICSP_BUF_BITS-9:0], rx_byte};
      len       = icsp_reg_len(ptr_q);
      mask      = icsp_reg_mask(ptr_q);
      byte_done = !start_pend && (cnt_q == ICSP_BIT_LAST);
      addr_hit  = (rx_byte[7:1] == DEV_ADDR);
      commit    = byte_done && (st_q == ICSP_D_WDATA) && (bidx_q == len - 5'h01);
      mack      = !start_pend && (cnt_q == ICSP_BIT_ACK) && !ack_q
                  && (st_q == ICSP_D_RDATA) && !bus.sda;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit counter and shift register; counting restarts at every start
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q   <= 4'h0;
         shift_q <= 7'h00;
      end
      else if (start_pend)
      begin
         cnt_q   <= 4'h1;
         shift_q <= {6'h00, bus.sda};
      end
      else if (cnt_q == ICSP_BIT_ACK)
         cnt_q   <= 4'h0;
      else
      begin
         cnt_q   <= cnt_q + 4'h1;
         shift_q <= {shift_q[5:0], bus.sda};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Acknowledge decision for the byte just completed
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else if (start_pend || !byte_done)
         ack_q <= 1'b0;
      else if (st_q == ICSP_D_ADDR)
         ack_q <= addr_hit;
      else
         ack_q <= (st_q == ICSP_D_SUB) || (st_q == ICSP_D_WDATA);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer state
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
         st_q <= ICSP_D_IGNORE;
      else if (start_pend)
         st_q <= ICSP_D_ADDR;
      else if (byte_done)
      begin
         case (st_q)
            ICSP_D_ADDR:
               st_q <= !addr_hit ? ICSP_D_IGNORE :
                       (rx_byte[0] ? ICSP_D_RDATA : ICSP_D_SUB);
            ICSP_D_SUB:
               st_q <= ICSP_D_WDATA;
            default:
               st_q <= st_q;
         endcase
      end
      else if ((cnt_q == ICSP_BIT_ACK) && !ack_q && (st_q == ICSP_D_RDATA) && bus.sda)
         st_q <= ICSP_D_IGNORE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register pointer and byte index within the current register
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr_q  <= 8'h00;
         bidx_q <= 5'h00;
      end
      else if (start_pend)
         bidx_q <= 5'h00;
      else if (byte_done && (st_q == ICSP_D_SUB))
      begin
         ptr_q  <= rx_byte;
         bidx_q <= 5'h00;
      end
      else if ((byte_done && (st_q == ICSP_D_WDATA)) || mack)
      begin
         if (bidx_q == len - 5'h01)
         begin
            ptr_q  <= ptr_q + 8'h01;
            bidx_q <= 5'h00;
         end
         else
            bidx_q <= bidx_q + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write collection; partial registers never reach the image
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
         wbuf_q <= '0;
      else if (byte_done && (st_q == ICSP_D_WDATA))
         wbuf_q <= wfull;
   end

   // Register image, updated only when a register's last byte arrives
   always_ff @(posedge bus.scl)
   begin
      if (commit)
      begin
         if (len == ICSP_LEN_BIQ)
         begin
            for (int w = 0; w < ICSP_BIQ_WORDS; w++)
               img[ptr_q][w] <= wfull[ICSP_BUF_BITS-1-32*w -: 32] & mask;
         end
         else
            img[ptr_q][0] <= wfull[31:0] & mask;
      end
   end

   // Commit record, held stable until the next commit for the core side
   always_ff @(posedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
      begin
         com_tgl_q  <= 1'b0;
         com_sub_q  <= 8'h00;
         com_len_q  <= 5'h00;
         com_data_q <= '0;
      end
      else if (commit)
      begin
         com_tgl_q  <= ~com_tgl_q;
         com_sub_q  <= ptr_q;
         com_len_q  <= len;
         com_data_q <= wfull;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read byte selection, big-endian within each word
   always_comb
   begin
      rd_word = img[ptr_q][bidx_q[4:2]];
      if (len == ICSP_LEN_CTRL)
         rd_byte = rd_word[7:0] & mask[7:0];
      else
      begin
         case (bidx_q[1:0])
            2'h0:    rd_byte = rd_word[31:24] & mask[31:24];
            2'h1:    rd_byte = rd_word[23:16] & mask[23:16];
            2'h2:    rd_byte = rd_word[15:8];
            default: rd_byte = rd_word[7:0];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data line drive, changed on the falling clock only
   always_ff @(negedge bus.scl or posedge rst_i)
   begin
      if (rst_i)
         sda_low_q <= 1'b0;
      else if (start_pend)
         sda_low_q <= 1'b0;
      else if ((cnt_q == ICSP_BIT_ACK) && ack_q)
         sda_low_q <= 1'b1;
      else if ((st_q == ICSP_D_RDATA) && (cnt_q < ICSP_BIT_ACK))
         sda_low_q <= ~rd_byte[~cnt_q[2:0]];
      else
         sda_low_q <= 1'b0;
   end

   // Open drain: only ever pulls low; the clock line has no driver here
   assign bus.sda_dev_o    = 1'b0;
   assign bus.sda_dev_en_n = ~sda_low_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Commit crossing into the core domain by toggle
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         sync_q <= 3'h0;
      else
         sync_q <= {sync_q[1:0], com_tgl_q};
   end

   // Record fields are stable for many link bits after the toggle moves
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         wr_valid_o <= 1'b0;
         wr_sub_o   <= 8'h00;
         wr_len_o   <= 5'h00;
         wr_data_o  <= '0;
      end
      else
      begin
         wr_valid_o <= sync_q[2] ^ sync_q[1];
         if (sync_q[2] ^ sync_q[1])
         begin
            wr_sub_o  <= com_sub_q;
            wr_len_o  <= com_len_q;
            wr_data_o <= com_data_q;
         end
      end
   end

endmodule

// ===== verilog/icsp_host.sv
`timescale 1ns/1ps
module icsp_host
   import icsp_pkg::*;
#(
   parameter int QTR_CYCLES = ICSP_QTR_CYC
)
(
   // Core clock and reset
   input  wire logic  core_clk_i,
   input  wire logic  rst_i,
   // Two-wire bus
   icsp_if.host       bus,
   // Byte command
   input  wire logic  cmd_valid_i,
   output logic       cmd_ready_o,
   input  wire logic  cmd_start_i,
   input  wire logic  cmd_stop_i,
   input  wire logic  cmd_read_i,
   input  wire logic  cmd_nack_i,
   input  wire logic [7:0] cmd_byte_i,
   // Byte answer
   output logic       rsp_valid_o,
   output logic [7:0] rsp_byte_o,
   output logic       rsp_nack_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   icsp_host_st_t st_q;
   logic [15:0]   div_q;
   logic          tick;
   logic [1:0]    ph_q;
   logic [3:0]    bit_q;
   logic [8:0]    tx_q;
   logic [7:0]    rx_q;
   logic          stop_q;
   logic          scl_q;
   logic          drv_q;
   logic [1:0]    sda_sync_q;
   logic          done;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         sda_sync_q <= 2'h3;
      else
         sda_sync_q <= {sda_sync_q[0], bus.sda};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Quarter-period divider, runs only while busy
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || st_q == ICSP_H_IDLE || tick)
         div_q <= 16'h0000;
      else
         div_q <= div_q + 16'h0001;
   end

   assign tick        = (div_q == 16'(QTR_CYCLES - 1));
   assign cmd_ready_o = (st_q == ICSP_H_IDLE);
   assign done        = tick && (ph_q == 2'h3)
                        && ((st_q == ICSP_H_STOP)
                            || (st_q == ICSP_H_BITS && bit_q == ICSP_BIT_ACK && !stop_q));

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer; transfer order is the caller's, this only frames bytes
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         st_q   <= ICSP_H_IDLE;
         ph_q   <= 2'h0;
         bit_q  <= 4'h0;
         tx_q   <= 9'h1FF;
         stop_q <= 1'b0;
      end
      else if (st_q == ICSP_H_IDLE)
      begin
         ph_q  <= 2'h0;
         bit_q <= 4'h0;
         if (cmd_valid_i)
         begin
            st_q   <= cmd_start_i ? ICSP_H_START : ICSP_H_BITS;
            stop_q <= cmd_stop_i;
            // Released data bits on reads; acknowledge bit chosen by caller
            tx_q   <= cmd_read_i ? {8'hFF, cmd_nack_i} : {cmd_byte_i, 1'b1};
         end
      end
      else if (tick)
      begin
         ph_q <= ph_q + 2'h1;
         if (ph_q == 2'h3)
         begin
            case (st_q)
               ICSP_H_START:
                  st_q <= ICSP_H_BITS;
               ICSP_H_BITS:
               begin
                  tx_q  <= {tx_q[7:0], 1'b1};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == ICSP_BIT_ACK)
                     st_q <= stop_q ? ICSP_H_STOP : ICSP_H_IDLE;
               end
               default:
                  st_q <= ICSP_H_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line drive per quarter: clock low on 0, data on 1, clock high on 2.
   // Data waits a quarter after the clock falls: a data fall in the same step
   // as the clock fall could be taken for a start by the target.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         scl_q <= 1'b1;
         drv_q <= 1'b0;
      end
      else if (tick)
      begin
         case (ph_q)
            2'h0:
               scl_q <= 1'b0;
            2'h1:
            begin
               if (st_q == ICSP_H_BITS)
                  drv_q <= ~tx_q[8];
               else
                  drv_q <= (st_q == ICSP_H_STOP);
            end
            2'h2:
               scl_q <= 1'b1;
            2'h3:
            begin
               if (st_q == ICSP_H_START)
                  drv_q <= 1'b1;
               else if (st_q == ICSP_H_STOP)
                  drv_q <= 1'b0;
            end
            default:
               scl_q <= scl_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive shift and answer
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         rx_q        <= 8'h00;
         rsp_valid_o <= 1'b0;
         rsp_byte_o  <= 8'h00;
         rsp_nack_o  <= 1'b0;
      end
      else
      begin
         rsp_valid_o <= done;
         if (tick && ph_q == 2'h3 && st_q == ICSP_H_BITS)
         begin
            if (bit_q == ICSP_BIT_ACK)
            begin
               rsp_byte_o <= rx_q;
               rsp_nack_o <= sda_sync_q[1];
            end
            else
               rx_q <= {rx_q[6:0], sda_sync_q[1]};
         end
      end
   end

   // Clock is push-pull, data is open drain
   assign bus.scl           = scl_q;
   assign bus.sda_host_o    = 1'b0;
   assign bus.sda_host_en_n = ~drv_q;

endmodule

// ===== test/icsp_properties.sv
`timescale 1ns/1ps
module icsp_properties
   import icsp_pkg::*;
#(
   parameter int QTR = 2
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_en_n,
   input wire logic sda_dev_en_n
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic       scl_q, sda_q, first_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   int         low_q;
   wire        start_w = scl & scl_q & sda_q & ~sda;
   wire        rise_w  = scl & ~scl_q;
   wire        ack_w   = rise_w & first_q & (bit_q == 4'h8);
   ////////////////////////////////////////////////////////
   // Line history, one core cycle back
   always_ff @(posedge core_clk_i)
   begin
      scl_q <= scl;
      sda_q <= sda;
   end
   // Length of the current clock-low phase
   always_ff @(posedge core_clk_i)
      low_q <= (rst_i || scl) ? 0 : low_q + 1;
   // Bit framing; a start restarts it, as the device must
   always_ff @(posedge core_clk_i)
      if (rst_i || start_w)
      begin
         bit_q   <= 4'h0;
         first_q <= 1'b1;
      end
      else if (rise_w)
      begin
         bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         if (bit_q == 4'h8)
            first_q <= 1'b0;
         else
            sh_q <= {sh_q[6:0], sda};
      end
   ////////////////////////////////////////////////////////
   chk_dev_edge_low: assert property ($changed(sda_dev_en_n) |-> !scl)
      else $error("device data moved while clock high");
   chk_scl_low_bounded: assert property (!scl |-> low_q <= 2 * QTR)
      else $error("clock held low too long");
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high phase too short");
   chk_ack_whole_period: assert property ($fell(sda_dev_en_n) |-> !sda_dev_en_n [*8])
      else $error("device released data within a period");
   chk_start_by_host: assert property (start_w |-> !sda_host_en_n)
      else $error("start not made by the master");
   chk_stop_clean: assert property (scl && scl_q && !sda_q && sda |-> $past(sda_dev_en_n))
      else $error("device data moved at a stop");
   chk_addr_ack: assert property (ack_w && sh_q[7:1] == ICSP_DEV_ADDR |-> !sda)
      else $error("own address not acknowledged");
   chk_addr_ignore: assert property (ack_w && sh_q[7:1] != ICSP_DEV_ADDR |-> sda_dev_en_n)
      else $error("foreign address acknowledged");
   // Main scenarios seen
   cover property (ack_w && !sda);
   cover property (ack_w && sda);
   cover property (!first_q && bit_q < 4'h8 && !sda_dev_en_n && scl);
endmodule

// ===== test/i2c_control_slave_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module i2c_control_slave_port_tb
   import icsp_pkg::*;
;
   logic         core_clk_i = 1'b0;
   logic         rst_i = 1'b0;
   logic         cmd_valid_i, cmd_ready_o, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i;
   logic [7:0]   cmd_byte_i, rsp_byte_o, wr_sub_o;
   logic         rsp_valid_o, rsp_nack_o, wr_valid_o;
   logic [4:0]   wr_len_o;
   logic [159:0] wr_data_o, exp_m;
   logic [159:0] mem [256];
   logic [175:0] exp_q [$];
   logic [175:0] exp_e;
   logic [31:0]  seed = 32'h00000053;
   logic [7:0]   subs [6] = '{8'h20, 8'h29, 8'h29, 8'h40, 8'h40, 8'h1E};
   int           lens [6] = '{6, 12, 20, 3, 4, 5};
   int           n_mismatch = 0;
   int           cmp_count = 0;

   always #5 core_clk_i = ~core_clk_i;
   icsp_if bus_if ();
   icsp_host #(.QTR_CYCLES(2)) icsp_host_i (.core_clk_i, .rst_i, .bus(bus_if), .cmd_valid_i,
      .cmd_ready_o, .cmd_start_i, .cmd_stop_i, .cmd_read_i, .cmd_nack_i, .cmd_byte_i,
      .rsp_valid_o, .rsp_byte_o, .rsp_nack_o);
   icsp_dev icsp_dev_i (.core_clk_i, .rst_i, .bus(bus_if), .wr_valid_o, .wr_sub_o,
      .wr_len_o, .wr_data_o);
   icsp_properties #(.QTR(2)) icsp_properties_i (.core_clk_i, .rst_i, .scl(bus_if.scl),
      .sda(bus_if.sda), .sda_host_en_n(bus_if.sda_host_en_n), .sda_dev_en_n(bus_if.sda_dev_en_n));
   ////////////////////////////////////////////////////////
   // Register class sizes and implemented bits, kept apart from the package
   function automatic int mlen(input logic [7:0] s);
      return (s <= 8'h1F) ? 1 : ((s >= 8'h29 && s <= 8'h3F) ? 20 : 4);
   endfunction
   function automatic logic [159:0] mmask(input logic [7:0] s);
      return (s <= 8'h1F) ? 160'hFF : ((s >= 8'h29 && s <= 8'h3F) ?
         {5{32'h03FFFFFF}} : 160'hFFFFFFFF);
   endfunction
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One byte command; reads check data, writes check the acknowledge level
   task automatic xfer(input logic s, p, r, k, input logic [7:0] b, e);
      int i;
      @(negedge core_clk_i);
      {cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i, cmd_byte_i} = {s, p, r, k, b};
      cmd_valid_i = 1'b1;
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      `CHK(cmd_ready_o, 1'b0)
      for (i = 0; i < 300 && rsp_valid_o !== 1'b1; i++)
         @(negedge core_clk_i);
      `CHK(rsp_valid_o, 1'b1)
      if (r)
         `CHK(rsp_byte_o, e)
      else
         `CHK(rsp_nack_o, e[0])
   endtask
   task automatic wr_frame(input logic [7:0] sub, input int n, input logic stp);
      logic [159:0] acc;
      logic [7:0]   p, b;
      int           cnt, i;
      acc = '0;
      cnt = 0;
      p = sub;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {ICSP_DEV_ADDR, 1'b0}, 8'h00);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, sub, 8'h00);
      for (i = 0; i < n; i++)
      begin
         b = rnd();
         acc = {acc[151:0], b};
         cnt++;
         // Only whole registers reach the model; a tail is dropped.
         // Queued before the byte goes out: the commit beats the answer.
         if (cnt == mlen(p))
         begin
            exp_q.push_back({p, 3'h0, 5'(cnt), acc});
            mem[p] = acc;
            p++;
            acc = '0;
            cnt = 0;
         end
         xfer(1'b0, stp && i == n - 1, 1'b0, 1'b0, b, 8'h00);
      end
   endtask
   task automatic rd_frame(input logic [7:0] sub, input int n);
      logic [7:0] p, eb;
      int         idx, i;
      p = sub;
      idx = 0;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {ICSP_DEV_ADDR, 1'b0}, 8'h00);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, sub, 8'h00);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {ICSP_DEV_ADDR, 1'b1}, 8'h00);
      for (i = 0; i < n; i++)
      begin
         eb = 8'((mem[p] & mmask(p)) >> (8 * (mlen(p) - 1 - idx)));
         xfer(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00, eb);
         idx++;
         if (idx == mlen(p))
         begin
            idx = 0;
            p++;
         end
      end
   endtask
   ////////////////////////////////////////////////////////
   // Each commit must be the next register the model completed
   always @(negedge core_clk_i)
      if (wr_valid_o === 1'b1)
      begin
         exp_e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
         exp_m = ~160'h0 >> (160 - 8 * wr_len_o);
         `CHK({wr_sub_o, 3'h0, wr_len_o, wr_data_o & exp_m}, exp_e)
      end
   // Main sequence
   initial
   begin
      {cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i, cmd_byte_i} = '0;
      // A real reset edge, so the line-clocked flops clear before any bus clock
      #1 rst_i = 1'b1;
      repeat (5) @(negedge core_clk_i);
      rst_i = 1'b0;
      wr_frame(8'h05, 3, 1'b1);
      rd_frame(8'h05, 3);
      xfer(1'b1, 1'b1, 1'b0, 1'b0, {ICSP_DEV_ADDR ^ 7'h01, 1'b0}, 8'h01);
      foreach (subs[j])
         wr_frame(subs[j], lens[j], 1'b1);
      wr_frame(8'h2A, 8, 1'b0);
      rd_frame(8'h29, 20);
      rd_frame(8'h20, 4);
      repeat (20) @(negedge core_clk_i);
      `CHK(exp_q.size(), 0)
      finish_test();
   end
   // Cut a hang short; the whole run needs about 90 us
   initial
   begin
      #400000;
      n_mismatch++;
      finish_test();
   end
endmodule
